// >>> src/adc_out_pkg.sv
// Purpose: shared constants and types for the converter output control block
// Assumes: 12-bit codes and a 40 MHz sample clock
// Notes:   register offsets are 13-bit serial-port addresses
package adc_out_pkg;
   // ***************************
   // register map
   // ***************************
   localparam logic [12:0] reg_chan_index  = 13'h005;
   localparam logic [12:0] reg_power_mode  = 13'h008;
   localparam logic [12:0] reg_output_mode = 13'h014;
   localparam logic [1:0]  chan_reset      = 2'h3;
   localparam logic [1:0]  pw_reset        = 2'h0;
   localparam logic [7:0]  om_reset        = 8'h00;
   localparam int          om_oeb_bit      = 4;
   localparam int          om_ilv_bit      = 5;
   localparam int          pw_status_bit   = 7;
   // ***************************
   // codes and encodings
   // ***************************
   localparam logic [1:0]  pw_normal       = 2'h0;
   localparam logic [1:0]  pw_down         = 2'h1;
   localparam logic [1:0]  pw_standby      = 2'h2;
   localparam logic [1:0]  fmt_offset      = 2'h0;
   localparam logic [1:0]  fmt_twos        = 2'h1;
   localparam logic [1:0]  fmt_gray        = 2'h2;
   localparam int          code_w          = 12;
   localparam int          in_w            = 14;
   localparam int          fd_w            = 4;
   localparam logic signed [13:0] in_max   = 14'sh07FF;
   localparam logic signed [13:0] in_min   = -14'sh0800;
   localparam logic [11:0] code_msb        = 12'h800;
   localparam logic [11:0] code_ones       = 12'hFFF;
   localparam logic [11:0] code_zero       = 12'h000;
   // ***************************
   // serial frame and buffering
   // ***************************
   localparam logic [4:0]  spi_instr_last  = 5'h0F;
   localparam logic [4:0]  spi_frame_last  = 5'h17;
   localparam logic [4:0]  spi_data_first  = 5'h10;
   localparam int          fifo_depth      = 16;
   typedef struct packed {
      logic [11:0] a;
      logic [11:0] b;
      logic        or_a;
      logic        or_b;
   } sample_s;
endpackage : adc_out_pkg

// >>> src/adc_output_power_control.sv
// Purpose: output coding, three-state, interleave and power control of a dual converter
// Assumes: all pins synchronous to clock; serial clock sampled by clock
// Notes:   a 16-word buffer sits between the converter core and the output port
`timescale 1ns/1ps

module sample_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
   logic             push, pop;

   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d = flush ? rd_q : wr_q + (AW+1)'(push);
      rd_d = rd_q + (AW+1)'(pop && !flush);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push && !flush) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule : sample_fifo

module adc_output_power_control
   import adc_out_pkg::*;
(
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     pin_mode,
   input  wire logic                     power_down_request,
   input  wire logic                     output_enable_bar,
   input  wire logic                     serial_clock_format_pin,
   input  wire logic                     spi_csb_n,
   input  wire logic                     serial_io_in,
   output logic                          serial_io_out,
   output logic                          serial_io_oe,
   output logic                          duty_cycle_stabilizer,
   input  wire logic signed [in_w-1:0]   sample_a,
   input  wire logic signed [in_w-1:0]   sample_b,
   input  wire logic                     sample_valid,
   output logic                          sample_ready,
   input  wire logic [fd_w-1:0]          fd_in_a,
   input  wire logic [fd_w-1:0]          fd_in_b,
   output logic [code_w-1:0]             port_a_data,
   output logic [code_w-1:0]             port_b_data,
   output logic                          overrange_a,
   output logic                          overrange_b,
   output logic [fd_w-1:0]               fast_detect_bits_a,
   output logic [fd_w-1:0]               fast_detect_bits_b,
   output logic                          port_a_oe,
   output logic                          port_b_oe,
   output logic                          data_clock_out,
   output logic                          ref_powered,
   output logic                          core_powered
);
   // ***************************
   // power and mode decode
   // ***************************
   logic [1:0] chan_q, chan_d, pw_q, pw_d, fmt_q, fmt_d;
   logic [1:0] oeb_q, oeb_d;
   logic       ilv_q, ilv_d;
   logic       pd_eff, standby, active, ilv;
   logic [1:0] fmt_eff;

   assign pd_eff  = power_down_request || (!pin_mode && pw_q == pw_down);
   assign standby = !pd_eff && !pin_mode && pw_q == pw_standby;
   assign active  = !pd_eff && !standby;
   assign ref_powered  = !pd_eff;
   assign core_powered = active;
   assign ilv     = !pin_mode && ilv_q;
   // pin mode: the serial clock pin doubles as the format strap
   assign fmt_eff = pin_mode ? (serial_clock_format_pin ? fmt_twos : fmt_offset) : fmt_q;
   assign duty_cycle_stabilizer = pin_mode && serial_io_in;

   // ***************************
   // coding
   // ***************************
   function automatic logic [11:0] encode(input logic signed [13:0] s, input logic [1:0] f);
      logic [11:0] ob;
      ob = (s > in_max) ? code_ones :
           (s < in_min) ? code_zero : s[11:0] ^ code_msb;
      unique case (f)
         fmt_twos: encode = ob ^ code_msb;
         fmt_gray: encode = ob ^ (ob >> 1);
         default:  encode = ob;
      endcase
   endfunction : encode

   sample_s in_word, out_word;
   logic    fifo_ready, fifo_valid, drain;

   always_comb begin
      in_word.a    = encode(sample_a, fmt_eff);
      in_word.b    = encode(sample_b, fmt_eff);
      in_word.or_a = (sample_a > in_max) || (sample_a < in_min);
      in_word.or_b = (sample_b > in_max) || (sample_b < in_min);
   end

   // lost samples while the core sleeps are dropped, not queued
   assign sample_ready = fifo_ready && active;

   sample_fifo #(.WIDTH($bits(sample_s)), .DEPTH(fifo_depth)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .flush     (!active),
      .in_data   (in_word),
      .in_valid  (sample_valid && active),
      .in_ready  (fifo_ready),
      .out_data  (out_word),
      .out_valid (fifo_valid),
      .out_ready (drain)
   );

   // ***************************
   // output port and data clock
   // ***************************
   logic [1:0]  ph_q, ph_d, last_ph;
   sample_s     hold_q, hold_d;
   logic [11:0] pa_q, pa_d, pb_q, pb_d;
   logic        ora_q, ora_d, orb_q, orb_d, dco_q, dco_d, oea_q, oea_d, oeb2_q, oeb2_d;
   logic [3:0]  fda_q, fda_d, fdb_q, fdb_d;

   assign last_ph = ilv ? 2'h3 : 2'h1;
   // one word per data clock period; an empty buffer repeats the last word
   assign drain   = active && ph_q == last_ph;

   always_comb begin
      ph_d   = (!active || ph_q == last_ph) ? 2'h0 : ph_q + 2'h1;
      hold_d = hold_q;
      pa_d   = pa_q;
      pb_d   = pb_q;
      ora_d  = ora_q;
      orb_d  = orb_q;
      if (drain && fifo_valid) begin
         hold_d = out_word;
         pa_d   = out_word.a;
         ora_d  = out_word.or_a;
         if (!ilv) begin
            pb_d  = out_word.b;
            orb_d = out_word.or_b;
         end
      end else if (ilv && ph_q == 2'h1) begin
         pa_d  = hold_q.b;
         ora_d = hold_q.or_b;
      end else if (ilv && ph_q == last_ph) begin
         // empty buffer: put channel A back so the rising capture stays A
         pa_d  = hold_q.a;
         ora_d = hold_q.or_a;
      end
      // rising edges, and falling edges when interleaved, sit mid-way between data changes so the receiver has margin
      dco_d  = active && (ph_d == 2'h1 || (ilv && ph_d == 2'h2));
      oea_d  = active && !output_enable_bar && !(!pin_mode && oeb_q[0]);
      oeb2_d = active && !output_enable_bar && !(!pin_mode && oeb_q[1]) && !ilv;
      fda_d  = fd_in_a;
      fdb_d  = fd_in_b;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ph_q   <= 2'h0;
         hold_q <= '0;
         pa_q   <= code_zero;
         pb_q   <= code_zero;
         ora_q  <= 1'b0;
         orb_q  <= 1'b0;
         dco_q  <= 1'b0;
         oea_q  <= 1'b0;
         oeb2_q <= 1'b0;
         fda_q  <= '0;
         fdb_q  <= '0;
      end else begin
         ph_q   <= ph_d;
         hold_q <= hold_d;
         pa_q   <= pa_d;
         pb_q   <= pb_d;
         ora_q  <= ora_d;
         orb_q  <= orb_d;
         dco_q  <= dco_d;
         oea_q  <= oea_d;
         oeb2_q <= oeb2_d;
         fda_q  <= fda_d;
         fdb_q  <= fdb_d;
      end
   end

   assign port_a_data        = pa_q;
   assign port_b_data        = pb_q;
   assign overrange_a        = ora_q;
   assign overrange_b        = orb_q;
   assign fast_detect_bits_a = fda_q;
   assign fast_detect_bits_b = fdb_q;
   assign port_a_oe          = oea_q;
   assign port_b_oe          = oeb2_q;
   assign data_clock_out     = dco_q;

   // ***************************
   // serial port registers
   // ***************************
   logic        sclk_q, sclk_d, rw_q, rw_d, sdo_q, sdo_d, sdoe_q, sdoe_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [12:0] addr_q, addr_d;
   logic [7:0]  rdata, wdata;
   logic        spi_en, rise, fall, wr;

   assign spi_en = !pin_mode && !spi_csb_n;
   assign rise   = spi_en && serial_clock_format_pin && !sclk_q;
   assign fall   = spi_en && !serial_clock_format_pin && sclk_q;
   assign wdata  = {sh_q[6:0], serial_io_in};
   assign wr     = rise && cnt_q == spi_frame_last && !rw_q;

   always_comb begin
      unique case (addr_q)
         reg_chan_index:  rdata = {6'h00, chan_q};
         reg_power_mode:  rdata = {!active, 5'h00, pw_q};
         reg_output_mode: rdata = {2'h0, ilv_q, oeb_q[chan_q[0] ? 0 : 1], 2'h0, fmt_q};
         default:         rdata = 8'h00;
      endcase
   end

   always_comb begin
      sclk_d = serial_clock_format_pin;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      rw_d   = rw_q;
      addr_d = addr_q;
      sdo_d  = sdo_q;
      sdoe_d = sdoe_q;
      chan_d = chan_q;
      pw_d   = pw_q;
      fmt_d  = fmt_q;
      ilv_d  = ilv_q;
      oeb_d  = oeb_q;
      if (!spi_en) begin
         cnt_d  = 5'h00;
         sdoe_d = 1'b0;
      end else if (rise) begin
         sh_d  = {sh_q[14:0], serial_io_in};
         cnt_d = (cnt_q == spi_frame_last) ? 5'h00 : cnt_q + 5'h01;
         if (cnt_q == spi_instr_last) begin
            rw_d   = sh_q[14];
            addr_d = {sh_q[11:0], serial_io_in};
         end
      end else if (fall && rw_q && cnt_q >= spi_data_first) begin
         sdo_d  = rdata[~cnt_q[2:0]];
         sdoe_d = 1'b1;
      end else if (fall) begin
         sdoe_d = 1'b0;
      end
      if (wr) begin
         unique case (addr_q)
            reg_chan_index: chan_d = wdata[1:0];
            reg_power_mode: pw_d   = wdata[1:0];
            reg_output_mode: begin
               fmt_d = (wdata[1:0] == 2'h3) ? fmt_offset : wdata[1:0];
               ilv_d = wdata[om_ilv_bit];
               if (chan_q[0]) oeb_d[0] = wdata[om_oeb_bit];
               if (chan_q[1]) oeb_d[1] = wdata[om_oeb_bit];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cnt_q  <= 5'h00;
         sh_q   <= 16'h0000;
         rw_q   <= 1'b0;
         addr_q <= 13'h0000;
         sdo_q  <= 1'b0;
         sdoe_q <= 1'b0;
         chan_q <= chan_reset;
         pw_q   <= pw_reset;
         fmt_q  <= om_reset[1:0];
         ilv_q  <= om_reset[om_ilv_bit];
         oeb_q  <= {2{om_reset[om_oeb_bit]}};
      end else begin
         sclk_q <= sclk_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         rw_q   <= rw_d;
         addr_q <= addr_d;
         sdo_q  <= sdo_d;
         sdoe_q <= sdoe_d;
         chan_q <= chan_d;
         pw_q   <= pw_d;
         fmt_q  <= fmt_d;
         ilv_q  <= ilv_d;
         oeb_q  <= oeb_d;
      end
   end

   assign serial_io_out = sdo_q;
   assign serial_io_oe  = sdoe_q;

   // ***************************
   // checks
   // ***************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_pin_on;
      pin_mode && !power_down_request && !output_enable_bar;
   endsequence
   sequence s_ilv_rise;
      ilv && active && $rose(data_clock_out);
   endsequence

   property p_pd_pin;
      power_down_request |-> !ref_powered && !core_powered;
   endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("power-down pin ignored");
   property p_pd_hiz;
      power_down_request ##1 power_down_request |-> !port_a_oe && !port_b_oe;
   endproperty
   a_pd_hiz: assert property (p_pd_hiz) else $error("drivers on in power-down");
   property p_wake;
      s_pin_on ##1 s_pin_on |-> core_powered && port_a_oe && port_b_oe;
   endproperty
   a_wake: assert property (p_wake) else $error("no return to normal");
   property p_standby;
      standby |-> ref_powered && !core_powered ##1 !port_a_oe;
   endproperty
   a_standby: assert property (p_standby) else $error("standby state wrong");
   property p_oeb_pin;
      output_enable_bar |=> !port_a_oe && !port_b_oe;
   endproperty
   a_oeb_pin: assert property (p_oeb_pin) else $error("oeb pin not obeyed");
   property p_ilv_clock;
      s_ilv_rise ##1 ilv |-> data_clock_out ##1 !data_clock_out && !port_b_oe;
   endproperty
   a_ilv_clock: assert property (p_ilv_clock) else $error("interleave clock wrong");
   property p_mid;
      fmt_eff == fmt_offset && sample_a == '0 |-> in_word.a == code_msb && !in_word.or_a;
   endproperty
   a_mid: assert property (p_mid) else $error("zero input code wrong");
   property p_clamp;
      fmt_eff == fmt_offset && sample_a < in_min |-> in_word.a == code_zero && in_word.or_a;
   endproperty
   a_clamp: assert property (p_clamp) else $error("negative clamp wrong");
   property p_twos;
      fmt_eff == fmt_twos && sample_b > in_max |-> in_word.b == 12'h7FF && in_word.or_b;
   endproperty
   a_twos: assert property (p_twos) else $error("twos code wrong");
endmodule : adc_output_power_control

// >>> sim/capture_model.sv
// Purpose: receiving capture register beside the converter output port
// Assumes: port A lines resolved by the bench from the driver enable
// Notes:   rise and fall captures queued for the bench to inspect
`timescale 1ns/1ps
module capture_model
   import adc_out_pkg::*;
(
   input  wire logic              data_clock_out,
   input  wire logic [code_w-1:0] bus_a
);
   logic [code_w-1:0] rise_q[$];
   logic [code_w-1:0] fall_q[$];
   // clocked only by the data clock, never by the sample clock
   always @(posedge data_clock_out) rise_q.push_back(bus_a);
   // falling capture only meaningful in interleaved mode
   always @(negedge data_clock_out) fall_q.push_back(bus_a);
endmodule : capture_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the converter output control block
// Assumes: serial clock pulses three sample clocks high and low
// Notes:   expected codes derived from clamped sample values
`timescale 1ns/1ps
module tb_top
   import adc_out_pkg::*;
;
   logic clock, rst, pin_mode, power_down_request, output_enable_bar;
   logic serial_clock_format_pin, spi_csb_n, serial_io_in, sample_valid;
   logic signed [in_w-1:0] sample_a, sample_b;
   logic [fd_w-1:0]        fd_in_a, fd_in_b, fast_detect_bits_a, fast_detect_bits_b;
   logic serial_io_out, serial_io_oe, duty_cycle_stabilizer, sample_ready;
   logic overrange_a, overrange_b, port_a_oe, port_b_oe;
   logic data_clock_out, ref_powered, core_powered;
   logic [code_w-1:0]      port_a_data, port_b_data;
   wire  [code_w-1:0]      bus_a;
   int mismatches, n_tests, nk, w, refused;
   int vals[8] = '{0, 2047, -2048, 2048, -2049, 8191, -8192, 1234};
   // released drivers float, so a capture of a three-stated port never matches
   assign bus_a = port_a_oe ? port_a_data : 'z;

   adc_output_power_control dut_u (.clock(clock), .rst(rst), .pin_mode(pin_mode),
      .power_down_request(power_down_request), .output_enable_bar(output_enable_bar),
      .serial_clock_format_pin(serial_clock_format_pin), .spi_csb_n(spi_csb_n),
      .serial_io_in(serial_io_in), .serial_io_out(serial_io_out),
      .serial_io_oe(serial_io_oe), .duty_cycle_stabilizer(duty_cycle_stabilizer),
      .sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .fd_in_a(fd_in_a), .fd_in_b(fd_in_b),
      .port_a_data(port_a_data), .port_b_data(port_b_data), .overrange_a(overrange_a),
      .overrange_b(overrange_b), .fast_detect_bits_a(fast_detect_bits_a),
      .fast_detect_bits_b(fast_detect_bits_b), .port_a_oe(port_a_oe),
      .port_b_oe(port_b_oe), .data_clock_out(data_clock_out),
      .ref_powered(ref_powered), .core_powered(core_powered));
   capture_model cap_u (.data_clock_out(data_clock_out), .bus_a(bus_a));

   // *****
   // tasks
   // *****
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : tick

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [11:0] enc(input int s, input logic [1:0] f);
      int c;
      logic [11:0] o;
      c = s > 2047 ? 2047 : (s < -2048 ? -2048 : s);
      o = 12'(c + 2048);
      if (f == fmt_twos) return o ^ code_msb;
      if (f == fmt_gray) return o ^ (o >> 1);
      return o;
   endfunction : enc

   task automatic spi(input logic rd, input logic [12:0] adr, input logic [7:0] wd,
                      output logic [7:0] rdat);
      logic [23:0] fr;
      fr = {rd, 2'h0, adr, wd};
      rdat = 8'h00;
      spi_csb_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_io_in = fr[i];
         tick(3);
         if (i < 8) rdat[i] = serial_io_out;
         if (i < 8) chk(serial_io_oe, rd);
         serial_clock_format_pin = 1'b1;
         tick(3);
         serial_clock_format_pin = 1'b0;
      end
      tick(3);
      spi_csb_n = 1'b1;
      tick(3);
      chk(serial_io_oe, 1'b0);
   endtask : spi

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi(1'b0, a, d, r);
      tick(3);
   endtask : wr

   task automatic rdc(input logic [12:0] a, input logic [7:0] e);
      logic [7:0] r;
      spi(1'b1, a, 8'h00, r);
      chk(r, e);
   endtask : rdc

   task automatic show(input int s, input logic [1:0] f);
      int sb;
      sb = s / 2;
      sample_a = s[in_w-1:0];
      sample_b = sb[in_w-1:0];
      sample_valid = 1'b1;
      tick(60);
      chk(port_a_data, enc(s, f));
      chk(port_b_data, enc(sb, f));
      chk(overrange_a, s > 2047 || s < -2048);
      chk(overrange_b, sb > 2047 || sb < -2048);
   endtask : show

   task automatic summarize();
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // *****
   // sequence
   // *****
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      tick(40000);
      mismatches++;
      summarize();
   end

   initial begin
      {rst, spi_csb_n} = 2'h3;
      {pin_mode, power_down_request, output_enable_bar} = 3'h0;
      {serial_clock_format_pin, serial_io_in, sample_valid} = 3'h0;
      sample_a = 14'h0000;
      sample_b = 14'h0000;
      fd_in_a = 4'hA;
      fd_in_b = 4'h5;
      mismatches = 0;
      n_tests = 0;
      tick(12);
      rst = 1'b0;
      tick(1);
      rdc(reg_chan_index, {6'h00, chan_reset});
      rdc(reg_power_mode, {6'h00, pw_reset});
      rdc(reg_output_mode, om_reset);
      wr(13'h0FF, 8'hFF);
      rdc(13'h0FF, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(reg_output_mode, {6'h00, f[1:0]});
         for (int k = 0; k < 8; k++) show(vals[k], f == 3 ? fmt_offset : f[1:0]);
      end
      chk({fast_detect_bits_a, fast_detect_bits_b}, 8'hA5);
      wr(reg_output_mode, {6'h00, fmt_gray});
      rdc(reg_output_mode, {6'h00, fmt_gray});
      pin_mode = 1'b1;
      for (int p = 0; p < 2; p++) begin
         serial_clock_format_pin = p[0];
         serial_io_in = p[0];
         for (int k = 0; k < 8; k++) show(vals[k], {1'b0, p[0]});
         chk(duty_cycle_stabilizer, p[0]);
      end
      {pin_mode, serial_clock_format_pin, serial_io_in, sample_valid} = 4'h0;
      tick(2);
      wr(reg_output_mode, 8'h00);
      power_down_request = 1'b1;
      tick(4);
      chk({port_a_oe, port_b_oe, ref_powered, core_powered, sample_ready}, 5'h00);
      power_down_request = 1'b0;
      tick(4);
      chk({port_a_oe, port_b_oe, ref_powered, core_powered, sample_ready}, 5'h1F);
      wr(reg_power_mode, {6'h00, pw_down});
      chk({port_a_oe, port_b_oe, ref_powered, core_powered, sample_ready}, 5'h00);
      rdc(reg_power_mode, 8'h81);
      wr(reg_power_mode, {6'h00, pw_standby});
      chk({ref_powered, core_powered, sample_ready}, 3'h4);
      rdc(reg_power_mode, 8'h82);
      wr(reg_power_mode, {6'h00, pw_normal});
      chk({ref_powered, core_powered, sample_ready}, 3'h7);
      // slow, configuration-style three-state changes only
      output_enable_bar = 1'b1;
      tick(4);
      chk({port_a_oe, port_b_oe}, 2'h0);
      output_enable_bar = 1'b0;
      tick(4);
      chk({port_a_oe, port_b_oe}, 2'h3);
      wr(reg_chan_index, 8'h01);
      wr(reg_output_mode, 8'h10);
      chk({port_a_oe, port_b_oe}, 2'h1);
      rdc(reg_output_mode, 8'h10);
      wr(reg_chan_index, 8'h02);
      wr(reg_output_mode, 8'h10);
      chk({port_a_oe, port_b_oe}, 2'h0);
      wr(reg_chan_index, 8'h03);
      wr(reg_output_mode, 8'h00);
      chk({port_a_oe, port_b_oe}, 2'h3);
      show(-2048, fmt_offset);
      sample_valid = 1'b0;
      tick(40);
      cap_u.rise_q.delete();
      refused = 0;
      for (int k = 1; k <= 48; k++) begin
         sample_a = k[in_w-1:0];
         sample_valid = 1'b1;
         w = 0;
         // ready is settled here and holds until the edge that takes the word
         while (sample_ready !== 1'b1 && w < 100) begin
            refused++;
            w++;
            tick(1);
         end
         tick(1);
      end
      sample_valid = 1'b0;
      chk(refused != 0, 1'b1);
      tick(120);
      chk(sample_ready, 1'b1);
      nk = 1;
      foreach (cap_u.rise_q[i]) if (cap_u.rise_q[i] === enc(nk, fmt_offset)) nk++;
      chk(16'(nk), 16'h0031);
      wr(reg_output_mode, 8'h20);
      sample_a = 14'h0064;
      sample_b = 14'h3F00;
      sample_valid = 1'b1;
      tick(100);
      cap_u.rise_q.delete();
      cap_u.fall_q.delete();
      tick(20);
      chk(cap_u.rise_q[0], enc(100, fmt_offset));
      chk(cap_u.fall_q[0], enc(-256, fmt_offset));
      chk(port_b_oe, 1'b0);
      // drained buffer: the last word must keep A on rise and B on fall
      sample_valid = 1'b0;
      tick(100);
      cap_u.rise_q.delete();
      cap_u.fall_q.delete();
      tick(20);
      chk(cap_u.rise_q[0], enc(100, fmt_offset));
      chk(cap_u.fall_q[0], enc(-256, fmt_offset));
      summarize();
   end
endmodule : tb_top
